// ### lpm_consts.svh
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH

// Special function register addresses
`define LPM_ADDR_EIRQ_EN2 8'he7
`define LPM_ADDR_EIRQ_PRI2 8'hf7
`define LPM_ADDR_PWR_CTRL 8'h87
`define LPM_ADDR_PWR_CFG 8'hb3

// Reset values
`define LPM_RST_EIRQ_EN2 8'h00
`define LPM_RST_EIRQ_PRI2 8'h00
`define LPM_RST_PWR_CTRL 8'h00
`define LPM_RST_PWR_CFG 8'h00

// Power control field positions
`define LPM_PC_IDLE 0
`define LPM_PC_STOP 1
// Power management configuration field positions
`define LPM_PM_WAKE_EN_LO 0
`define LPM_PM_WAKE_EN_HI 3
`define LPM_PM_SUSPEND 6
`define LPM_PM_SLEEP 7

// Number of wake-capable interrupt sources in the extended registers
`define LPM_NUM_XIRQ 4
// Resume vector after any reset
`define LPM_RESET_VECTOR 16'h0000

`endif

// ### lpm_pkg.sv
package lpm_pkg;

	typedef enum logic [2:0] {
		LPM_NORMAL = 3'b000,
		LPM_IDLE = 3'b001,
		LPM_STOP = 3'b010,
		LPM_SUSPEND = 3'b011,
		LPM_SLEEP = 3'b100
	} lpm_mode_type;

	typedef struct packed {
		logic [7:0] irq_en;
		logic [7:0] irq_pri;
		logic [7:0] pwr_ctrl;
		logic [7:0] pwr_cfg;
		logic [7:0] rdata;
	} lpm_regs_type;

endpackage

// ### lpm_ctl_if.sv
`timescale 1ns/1ps
interface lpm_ctl_if;
	logic idle_req;
	logic stop_req;
	logic suspend_req;
	logic sleep_req;
	logic [3:0] wake_en;
	logic [7:0] irq_en;
	logic [7:0] irq_pri;
	logic idle_clear;
	logic suspend_clear;

	modport regs (
		output idle_req, stop_req, suspend_req, sleep_req, wake_en,
		output irq_en, irq_pri,
		input idle_clear, suspend_clear
	);
	modport seq (
		input idle_req, stop_req, suspend_req, sleep_req, wake_en,
		input irq_en, irq_pri,
		output idle_clear, suspend_clear
	);
endinterface

// ### lpm_regs.sv
`timescale 1ns/1ps
`include "lpm_consts.svh"
module lpm_regs
	import lpm_pkg::*;
(
	input wire logic sys_clk_i, // System clock
	input wire logic srst_i, // Synchronous reset
	input wire logic sfr_wr_i, // Register write strobe
	input wire logic sfr_rd_i, // Register read strobe
	input wire logic [7:0] sfr_addr_i, // Register address
	input wire logic [7:0] sfr_wdata_i, // Write data
	output logic [7:0] sfr_rdata_o, // Read data
	lpm_ctl_if.regs ctl // Mode controls
);
	lpm_regs_type state_reg;
	lpm_regs_type state_next;
	logic wr_en2;
	logic wr_pri2;
	logic wr_pc;
	logic wr_pm;

	always_comb
	begin
		state_next = state_reg;
		wr_en2 = sfr_wr_i && sfr_addr_i == `LPM_ADDR_EIRQ_EN2;
		wr_pri2 = sfr_wr_i && sfr_addr_i == `LPM_ADDR_EIRQ_PRI2;
		wr_pc = sfr_wr_i && sfr_addr_i == `LPM_ADDR_PWR_CTRL;
		wr_pm = sfr_wr_i && sfr_addr_i == `LPM_ADDR_PWR_CFG;
		if (wr_en2)
			state_next.irq_en = {4'h0, sfr_wdata_i[3:0]};
		if (wr_pri2)
			state_next.irq_pri = {4'h0, sfr_wdata_i[3:0]};
		if (wr_pc)
			state_next.pwr_ctrl = sfr_wdata_i;
		else
			state_next.pwr_ctrl[`LPM_PC_STOP] = 1'b0;
		// Wake clears idle; a fresh write in the same cycle wins
		if (ctl.idle_clear && !wr_pc)
			state_next.pwr_ctrl[`LPM_PC_IDLE] = 1'b0;
		if (wr_pm)
			state_next.pwr_cfg = sfr_wdata_i;
		if (ctl.suspend_clear && !wr_pm)
		begin
			state_next.pwr_cfg[`LPM_PM_SUSPEND] = 1'b0;
			state_next.pwr_cfg[`LPM_PM_SLEEP] = 1'b0;
		end
		state_next.rdata = 8'h00;
		if (sfr_rd_i)
		begin
			unique case (sfr_addr_i)
				`LPM_ADDR_EIRQ_EN2: state_next.rdata = state_reg.irq_en;
				`LPM_ADDR_EIRQ_PRI2: state_next.rdata = state_reg.irq_pri;
				`LPM_ADDR_PWR_CTRL: state_next.rdata =
					state_reg.pwr_ctrl & 8'hfd;
				`LPM_ADDR_PWR_CFG: state_next.rdata = state_reg.pwr_cfg;
				default: state_next.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			state_reg.irq_en <= `LPM_RST_EIRQ_EN2;
			state_reg.irq_pri <= `LPM_RST_EIRQ_PRI2;
			state_reg.pwr_ctrl <= `LPM_RST_PWR_CTRL;
			state_reg.pwr_cfg <= `LPM_RST_PWR_CFG;
			state_reg.rdata <= 8'h00;
		end
		else
			state_reg <= state_next;
	end

	assign sfr_rdata_o = state_reg.rdata;
	assign ctl.idle_req = state_reg.pwr_ctrl[`LPM_PC_IDLE];
	assign ctl.stop_req = state_reg.pwr_ctrl[`LPM_PC_STOP];
	assign ctl.suspend_req = state_reg.pwr_cfg[`LPM_PM_SUSPEND];
	assign ctl.sleep_req = state_reg.pwr_cfg[`LPM_PM_SLEEP];
	assign ctl.wake_en =
		state_reg.pwr_cfg[`LPM_PM_WAKE_EN_HI:`LPM_PM_WAKE_EN_LO];
	assign ctl.irq_en = state_reg.irq_en;
	assign ctl.irq_pri = state_reg.irq_pri;
endmodule

// ### lpm_seq.sv
`timescale 1ns/1ps
`include "lpm_consts.svh"
module lpm_seq
	import lpm_pkg::*;
#(
	parameter int NUM_XIRQ = `LPM_NUM_XIRQ
)
(
	input wire logic sys_clk_i, // System clock
	input wire logic srst_i, // Synchronous reset
	input wire logic instr_retire_i, // Writing instruction completed
	input wire logic any_irq_i, // Any enabled core interrupt
	input wire logic [NUM_XIRQ-1:0] xirq_raw_i, // Synced extended sources
	input wire logic [3:0] wake_evt_i, // Synced wake events
	output logic cpu_halt_o, // Core halted
	output logic clk_stop_o, // Internal clocks stopped
	output logic osc_halt_o, // Oscillators halted
	output logic power_down_o, // Power nets off, retention on
	output logic [NUM_XIRQ-1:0] xirq_hi_o, // High-priority requests
	output logic [NUM_XIRQ-1:0] xirq_lo_o, // Low-priority requests
	output logic [15:0] reset_vector_o, // Fetch address after reset
	output lpm_mode_type mode_o, // Current mode
	lpm_ctl_if.seq ctl // Mode controls
);
	typedef struct packed {
		lpm_mode_type mode;
		logic pend_idle;
		logic pend_stop;
		logic pend_susp;
		logic pend_sleep;
		logic [NUM_XIRQ-1:0] hi;
		logic [NUM_XIRQ-1:0] lo;
		logic idle_clr;
		logic susp_clr;
	} lpm_seq_type;

	lpm_seq_type state_reg;
	lpm_seq_type state_next;
	logic xirq_any;

	// Only four extended enable and priority bits exist
	if (NUM_XIRQ < 1 || NUM_XIRQ > `LPM_NUM_XIRQ)
	begin : g_bad_num
		$error("NUM_XIRQ out of range");
	end

	always_comb
	begin
		state_next = state_reg;
		state_next.idle_clr = 1'b0;
		state_next.susp_clr = 1'b0;
		// Requests wait for the writing instruction to retire
		// Mode bits still show for one cycle after a wake
		if (ctl.idle_req && state_reg.mode == LPM_NORMAL
			&& !state_reg.idle_clr)
			state_next.pend_idle = 1'b1;
		if (ctl.stop_req)
			state_next.pend_stop = 1'b1;
		if (state_reg.mode == LPM_NORMAL && !state_reg.susp_clr)
		begin
			if (ctl.sleep_req)
				state_next.pend_sleep = 1'b1;
			else if (ctl.suspend_req)
				state_next.pend_susp = 1'b1;
		end
		for (int i = 0; i < NUM_XIRQ; i++)
		begin
			state_next.hi[i] = xirq_raw_i[i] && ctl.irq_en[i]
				&& ctl.irq_pri[i];
			state_next.lo[i] = xirq_raw_i[i] && ctl.irq_en[i]
				&& !ctl.irq_pri[i];
		end
		unique case (state_reg.mode)
			LPM_NORMAL:
			begin
				if (instr_retire_i)
				begin
					// Stop wins over other pending requests
					if (state_reg.pend_stop)
						state_next.mode = LPM_STOP;
					else if (state_reg.pend_sleep)
						state_next.mode = LPM_SLEEP;
					else if (state_reg.pend_susp)
						state_next.mode = LPM_SUSPEND;
					else if (state_reg.pend_idle)
						state_next.mode = LPM_IDLE;
					state_next.pend_stop = 1'b0;
					state_next.pend_sleep = 1'b0;
					state_next.pend_susp = 1'b0;
					state_next.pend_idle = 1'b0;
				end
			end
			LPM_IDLE:
				if (any_irq_i || xirq_any)
				begin
					state_next.mode = LPM_NORMAL;
					state_next.idle_clr = 1'b1;
				end
			LPM_STOP:
				state_next.mode = LPM_STOP;
			LPM_SUSPEND, LPM_SLEEP:
				if (|(wake_evt_i & ctl.wake_en))
				begin
					state_next.mode = LPM_NORMAL;
					state_next.susp_clr = 1'b1;
				end
			default:
				state_next.mode = LPM_NORMAL;
		endcase
	end

	assign xirq_any = |(state_reg.hi | state_reg.lo);

	// Any reset ends every mode (watchdog, missing clock, pin)
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign mode_o = state_reg.mode;
	assign cpu_halt_o = state_reg.mode != LPM_NORMAL;
	assign clk_stop_o = state_reg.mode == LPM_STOP;
	assign osc_halt_o = state_reg.mode == LPM_SUSPEND ||
		state_reg.mode == LPM_SLEEP;
	assign power_down_o = state_reg.mode == LPM_SLEEP;
	assign xirq_hi_o = state_reg.hi;
	assign xirq_lo_o = state_reg.lo;
	assign reset_vector_o = `LPM_RESET_VECTOR;
	assign ctl.idle_clear = state_reg.idle_clr;
	assign ctl.suspend_clear = state_reg.susp_clr;
endmodule

// ### lpm_top.sv
// Behaviour
// - Idle write halts CPU after instruction
// - Idle keeps peripherals and clocks running
// - Idle retains registers and memory
// - Enabled interrupt clears idle, resumes CPU
// - Service interrupt, then continue after idle
// - Reset ends idle, fetch from zero
// - Watchdog timeout reset ends idle
// - Stop write halts CPU and clocks
// - Stop keeps analog state, removes clock
// - Only reset ends stop, fetch zero
// - Missing clock reset ends stop
// - Only four wake events or reset end suspend/sleep
// - Wake resumes after requesting instruction
// - Sleep powers down, retains state and pins
// - Enable bits 3:0 unmask four interrupts
// - Priority bits 3:0 select high priority
// - Stop bit always reads zero
// - Enabled wake or reset ends suspend
`timescale 1ns/1ps
`include "lpm_consts.svh"
module lpm_top
	import lpm_pkg::*;
#(
	parameter int NUM_XIRQ = `LPM_NUM_XIRQ
)
(
	input wire logic sys_clk_i, // System clock, 100 MHz
	input wire logic srst_i, // Any device reset
	input wire logic sfr_wr_i, // Register write strobe
	input wire logic sfr_rd_i, // Register read strobe
	input wire logic [7:0] sfr_addr_i, // Register address
	input wire logic [7:0] sfr_wdata_i, // Write data
	output logic [7:0] sfr_rdata_o, // Read data
	input wire logic instr_retire_i, // Instruction completed
	input wire logic any_irq_i, // Other enabled interrupt pending
	input wire logic [NUM_XIRQ-1:0] xirq_i, // Extended irq sources, async
	input wire logic [3:0] wake_evt_i, // Wake events, async
	output logic cpu_halt_o, // Core halted
	output logic clk_stop_o, // Clocks stopped
	output logic osc_halt_o, // Oscillators halted
	output logic power_down_o, // Sleep power-down
	output logic [NUM_XIRQ-1:0] xirq_hi_o, // High-priority requests
	output logic [NUM_XIRQ-1:0] xirq_lo_o, // Low-priority requests
	output logic [15:0] reset_vector_o, // Fetch address after reset
	output lpm_mode_type mode_o // Current mode
);
	typedef struct packed {
		logic [NUM_XIRQ-1:0] xirq_s1;
		logic [NUM_XIRQ-1:0] xirq_s2;
		logic [3:0] wake_s1;
		logic [3:0] wake_s2;
	} lpm_sync_type;

	lpm_sync_type sync_reg;
	lpm_sync_type sync_next;
	lpm_ctl_if ctl ();

	always_comb
	begin
		sync_next.xirq_s1 = xirq_i;
		sync_next.xirq_s2 = sync_reg.xirq_s1;
		sync_next.wake_s1 = wake_evt_i;
		sync_next.wake_s2 = sync_reg.wake_s1;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			sync_reg <= '0;
		else
			sync_reg <= sync_next;
	end

	lpm_regs u_regs (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.sfr_wr_i(sfr_wr_i),
		.sfr_rd_i(sfr_rd_i),
		.sfr_addr_i(sfr_addr_i),
		.sfr_wdata_i(sfr_wdata_i),
		.sfr_rdata_o(sfr_rdata_o),
		.ctl(ctl)
	);

	lpm_seq #(.NUM_XIRQ(NUM_XIRQ)) u_seq (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.instr_retire_i(instr_retire_i),
		.any_irq_i(any_irq_i),
		.xirq_raw_i(sync_reg.xirq_s2),
		.wake_evt_i(sync_reg.wake_s2),
		.cpu_halt_o(cpu_halt_o),
		.clk_stop_o(clk_stop_o),
		.osc_halt_o(osc_halt_o),
		.power_down_o(power_down_o),
		.xirq_hi_o(xirq_hi_o),
		.xirq_lo_o(xirq_lo_o),
		.reset_vector_o(reset_vector_o),
		.mode_o(mode_o),
		.ctl(ctl)
	);
endmodule

// ### lpm_properties.sv
`timescale 1ns/1ps
module lpm_chk
	import lpm_pkg::*;
(
	input wire logic sys_clk_i, // Clock
	input wire logic srst_i, // Reset
	input wire logic sfr_wr_i, // Write strobe
	input wire logic sfr_rd_i, // Read strobe
	input wire logic [7:0] sfr_addr_i, // Address
	input wire logic [7:0] sfr_wdata_i, // Write data
	input wire logic [7:0] sfr_rdata_o, // Read data
	input wire logic instr_retire_i, // Retire
	input wire logic any_irq_i, // Interrupt
	input wire logic cpu_halt_o, // Halt
	input wire logic clk_stop_o, // Clock stop
	input wire logic osc_halt_o, // Osc halt
	input wire logic power_down_o, // Power down
	input wire logic [15:0] reset_vector_o, // Vector
	input wire lpm_mode_type mode_o // Mode
);
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (srst_i);

	sequence idle_wr_s;
		sfr_wr_i && sfr_addr_i == 8'h87 && sfr_wdata_i == 8'h01
			&& mode_o == LPM_NORMAL;
	endsequence
	sequence retire_s;
		!instr_retire_i ##1 instr_retire_i && !any_irq_i;
	endsequence

	a_idle_entry: assert property (idle_wr_s ##1 retire_s
		|=> mode_o == LPM_IDLE)
		else $error("idle not entered after retire");
	a_wait_retire: assert property (mode_o == LPM_NORMAL
		&& !instr_retire_i |=> mode_o == LPM_NORMAL)
		else $error("mode left normal without retire");
	a_halt_mode: assert property (cpu_halt_o
		== (mode_o != LPM_NORMAL))
		else $error("halt disagrees with mode");
	a_stop_clock: assert property (clk_stop_o
		== (mode_o == LPM_STOP))
		else $error("clock stop disagrees with mode");
	a_stop_holds: assert property (mode_o == LPM_STOP
		|=> mode_o == LPM_STOP)
		else $error("stop left without reset");
	a_idle_wake: assert property (mode_o == LPM_IDLE
		&& any_irq_i |=> mode_o == LPM_NORMAL)
		else $error("interrupt did not end idle");
	a_stop_reads_zero: assert property (sfr_rd_i
		&& sfr_addr_i == 8'h87 |=> !sfr_rdata_o[1])
		else $error("stop bit read as one");
	a_upper_zero: assert property (sfr_rd_i
		&& (sfr_addr_i == 8'he7 || sfr_addr_i == 8'hf7)
		|=> sfr_rdata_o[7:4] == 4'h0)
		else $error("reserved bits read nonzero");
	a_sleep_power: assert property (
		power_down_o == (mode_o == LPM_SLEEP)
		&& osc_halt_o == (mode_o inside {LPM_SUSPEND, LPM_SLEEP}))
		else $error("power outputs disagree with mode");
	a_vector_zero: assert property (reset_vector_o == 16'h0000)
		else $error("reset vector not zero");
endmodule

bind lpm_top lpm_chk chk_u (.sys_clk_i, .srst_i, .sfr_wr_i, .sfr_rd_i,
	.sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o, .instr_retire_i, .any_irq_i,
	.cpu_halt_o, .clk_stop_o, .osc_halt_o, .power_down_o, .reset_vector_o,
	.mode_o);

// ### lpm_core_model.sv
`timescale 1ns/1ps
module lpm_core_model
(
	input wire logic clk_i, // System clock
	input wire logic start_i, // Instruction issued
	input wire logic [3:0] lat_i, // Cycles to completion
	output logic retire_o // Instruction completed
);
	logic busy_reg = 1'h0;
	logic [3:0] cnt_reg = 4'h0;
	always @(posedge clk_i)
	begin
		if (start_i)
		begin
			busy_reg <= 1'h1;
			cnt_reg <= lat_i;
		end
		else if (busy_reg && cnt_reg == 4'h0)
			busy_reg <= 1'h0;
		else
			cnt_reg <= cnt_reg - 4'h1;
	end
	// Writer plus its multi-byte follower complete late
	assign retire_o = busy_reg && cnt_reg == 4'h0;
endmodule

// ### lpm_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module lpm_top_tb
	import lpm_pkg::*;
;
	logic sys_clk_i = 1'h0;
	logic srst_i = 1'h1;
	logic sfr_wr_i = 1'h0;
	logic sfr_rd_i = 1'h0;
	logic any_irq_i = 1'h0;
	logic [7:0] sfr_addr_i = 8'h00;
	logic [7:0] sfr_wdata_i = 8'h00;
	logic [7:0] sfr_rdata_o, q, v;
	logic [3:0] xirq_i = 4'h0;
	logic [3:0] wake_evt_i = 4'h0;
	logic [3:0] lat = 4'h1;
	logic [3:0] hi, lo, en, pri;
	logic retire, cpu_halt_o, clk_stop_o, osc_halt_o, power_down_o;
	logic [15:0] reset_vector_o;
	lpm_mode_type mode_o, m;
	logic [7:0] adr [5] = '{8'he7, 8'hf7, 8'h87, 8'hb3, 8'h55};
	logic [7:0] cfg [3] = '{8'h40, 8'h80, 8'hc0};
	int mismatches = 0;
	int checked = 0;
	int n, k;

	always #5 sys_clk_i = ~sys_clk_i;

	lpm_top dut_u (.sys_clk_i, .srst_i, .sfr_wr_i, .sfr_rd_i, .sfr_addr_i,
		.sfr_wdata_i, .sfr_rdata_o, .instr_retire_i(retire), .any_irq_i,
		.xirq_i, .wake_evt_i, .cpu_halt_o, .clk_stop_o, .osc_halt_o,
		.power_down_o, .xirq_hi_o(hi), .xirq_lo_o(lo), .reset_vector_o,
		.mode_o);
	lpm_core_model core_u (.clk_i(sys_clk_i), .start_i(sfr_wr_i),
		.lat_i(lat), .retire_o(retire));

	function automatic logic [3:0] exp_req(input logic [3:0] x, e, p);
		return x & e & p;
	endfunction
	function automatic lpm_mode_type exp_mode(input logic [7:0] c);
		return c[7] ? LPM_SLEEP : LPM_SUSPEND;
	endfunction

	task automatic cyc(input int c);
		repeat (c) @(negedge sys_clk_i);
	endtask
	task automatic close_out();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_wr_i = 1'h1;
		sfr_addr_i = a;
		sfr_wdata_i = d;
		cyc(1);
		sfr_wr_i = 1'h0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a);
		sfr_rd_i = 1'h1;
		sfr_addr_i = a;
		cyc(1);
		sfr_rd_i = 1'h0;
		q = sfr_rdata_o;
		cyc(1);
	endtask
	task automatic wait_mode(input lpm_mode_type w);
		n = 0;
		while (mode_o !== w && n < 20)
		begin
			cyc(1);
			n++;
		end
		if (mode_o !== w)
		begin
			mismatches++;
			$display("[FAIL] %0t mode wait timed out", $time);
			close_out();
		end
	endtask

	initial
	begin
		#200000;
		mismatches++;
		$display("[FAIL] %0t run timed out", $time);
		close_out();
	end

	initial
	begin
		void'($urandom(47));
		cyc(5);
		srst_i = 1'h0;
		for (int i = 0; i < 5; i++)
		begin
			rd(adr[i]);
			`CHK(q, 8'h00)
		end
		$display("test reset done");
		repeat (6)
		begin
			v = 8'($urandom);
			wr(8'he7, v);
			rd(8'he7);
			`CHK(q, {4'h0, v[3:0]})
			v = 8'($urandom);
			wr(8'hf7, v);
			rd(8'hf7);
			`CHK(q, {4'h0, v[3:0]})
			en = 4'($urandom);
			pri = 4'($urandom);
			xirq_i = 4'($urandom);
			wr(8'he7, {4'h0, en});
			wr(8'hf7, {4'h0, pri});
			cyc(5);
			`CHK(hi, exp_req(xirq_i, en, pri))
			`CHK(lo, exp_req(xirq_i, en, ~pri))
		end
		xirq_i = 4'h0;
		wr(8'h55, 8'hff);
		rd(8'h55);
		`CHK(q, 8'h00)
		$display("test registers done");
		for (k = 1; k < 5; k++)
		begin
			lat = 4'(k);
			wr(8'he7, 8'h01);
			wr(8'h87, 8'h01);
			cyc(k - 1);
			`CHK(mode_o, LPM_NORMAL)
			cyc(1);
			`CHK(mode_o, LPM_IDLE)
			rd(8'he7);
			`CHK(q, 8'h01)
			if (k % 2 == 1)
			begin
				any_irq_i = 1'h1;
				cyc(1);
				any_irq_i = 1'h0;
			end
			else
			begin
				xirq_i = 4'h2;
				cyc(6);
				`CHK(mode_o, LPM_IDLE)
				xirq_i = 4'h1;
				wait_mode(LPM_NORMAL);
				xirq_i = 4'h0;
			end
			`CHK(mode_o, LPM_NORMAL)
			cyc(1);
			rd(8'h87);
			`CHK(q[0], 1'h0)
		end
		$display("test idle done");
		wr(8'h87, 8'h02);
		wait_mode(LPM_STOP);
		`CHK(clk_stop_o, 1'h1)
		any_irq_i = 1'h1;
		wake_evt_i = 4'hf;
		xirq_i = 4'hf;
		cyc(8);
		`CHK(mode_o, LPM_STOP)
		srst_i = 1'h1;
		cyc(1);
		srst_i = 1'h0;
		any_irq_i = 1'h0;
		wake_evt_i = 4'h0;
		xirq_i = 4'h0;
		`CHK(mode_o, LPM_NORMAL)
		`CHK(reset_vector_o, 16'h0000)
		rd(8'he7);
		`CHK(q, 8'h00)
		$display("test stop done");
		for (int i = 0; i < 3; i++)
		begin
			k = $urandom_range(3, 0);
			lat = 4'($urandom_range(6, 1));
			m = exp_mode(cfg[i]);
			wr(8'hb3, cfg[i] | (8'h01 << k));
			wait_mode(m);
			`CHK(osc_halt_o, 1'h1)
			`CHK(power_down_o, cfg[i][7])
			wake_evt_i = 4'h1 << ((k + 1) % 4);
			any_irq_i = 1'h1;
			cyc(6);
			`CHK(mode_o, m)
			any_irq_i = 1'h0;
			wake_evt_i = 4'h1 << k;
			wait_mode(LPM_NORMAL);
			`CHK(cpu_halt_o, 1'h0)
			wake_evt_i = 4'h0;
			cyc(2);
			rd(8'hb3);
			`CHK(q[7:6], 2'h0)
		end
		$display("test suspend sleep done");
		close_out();
	end
endmodule
